// *** src/iwu_unit.sv ***
// Chosen here: the register offsets and register access over APB.
`default_nettype none

module iwu_unit #(
    parameter int unsigned TICK_CYCLES = iwu_pkg::WDT_TICK_CYCLES
) (
    // Clock and reset.
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // APB slave.
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [11:0]           paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    // Core and event side.
    input  wire iwu_pkg::iwu_core_cmd_s core_cmd,
    input  wire iwu_pkg::iwu_event_in_s events,
    output logic                       irq_req,
    output logic                       fetch_redirect,
    output logic      [9:0]            fetch_vector,
    output logic                       wdt_reset
);
    import iwu_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Registers and state.
    logic [7:0]  flag_reg;         // Sticky event flags.
    logic [7:0]  enable_reg;       // Per-source enables.
    logic [7:0]  power_reg;        // Run bit, prescaler assign and select.
    logic [7:0]  config_reg;       // Watchdog configuration.
    logic [7:0]  port_cfg_reg;     // Wake bits, external select and edge.
    logic        gie_reg;          // Global interrupt enable.
    logic        timeout_reg;      // Timeout status, low after a timeout.
    logic [5:0]  pins_prev_reg;    // Pin levels one cycle ago.
    logic        lvd_prev_reg;     // Detector level one cycle ago.
    logic [15:0] tick_cnt_reg;     // Divider for the watchdog base tick.
    logic [8:0]  wdt_cnt_reg;      // Base period counter in ticks.
    logic [7:0]  pre_cnt_reg;      // Prescaler counter of base periods.
    logic [7:0]  flag_next;        // Next flag value.
    logic [7:0]  set_vec;          // Hardware set requests this cycle.
    logic [5:0]  change_vec;       // Qualified pin level changes.
    logic        flag_wr;          // Firmware write to the flag register.
    logic        take_irq;         // Hardware interrupt accepted.
    logic        wdt_running;      // Watchdog enabled and started.
    logic        wdt_tick;         // One-cycle base tick.
    logic        base_expire;      // Base period reached this tick.
    logic        wdt_timeout;      // Full timeout this cycle.
    logic [8:0]  period_ticks;     // Selected base period.
    logic [7:0]  pre_limit;        // Prescaler ratio minus one.
    logic        ext_edge;         // Selected edge seen on pin zero.
    logic [31:0] read_mux;         // Read data for the addressed register.
    logic        addr_ok;          // Address is mapped.

    ////////////////////////////////////////////////////////////////////////////
    // APB decode; the slave never inserts wait states.
    assign pready  = 1'b1;
    assign addr_ok = (paddr == OFS_FLAG) || (paddr == OFS_ENABLE) ||
                     (paddr == OFS_POWER) || (paddr == OFS_CONFIG) ||
                     (paddr == OFS_PORT_CFG) || (paddr == OFS_STATUS);
    assign flag_wr = psel && penable && pwrite && (paddr == OFS_FLAG);

    // Read multiplexer; flags show only where enabled.
    // Reading never clears a flag, so polling has no side effect.
    always_comb begin
        read_mux = 32'h0000_0000;
        unique case (paddr)
            OFS_FLAG:     read_mux[7:0] = flag_reg & enable_reg;
            OFS_ENABLE:   read_mux[7:0] = enable_reg;
            OFS_POWER:    read_mux[7:0] = power_reg;
            OFS_CONFIG:   read_mux[7:0] = config_reg;
            OFS_PORT_CFG: read_mux[7:0] = port_cfg_reg;
            OFS_STATUS: begin
                read_mux[BIT_TIMEOUT] = timeout_reg;
                read_mux[BIT_GIE]     = gie_reg;
            end
            default:      read_mux = 32'h0000_0000;
        endcase
    end

    // Read data and error are captured in the setup cycle.
    // That keeps prdata steady through every access cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            prdata  <= pwrite ? 32'h0000_0000 : read_mux;
            pslverr <= !addr_ok;
        end
    end

    // Plain control registers written in the access cycle.
    // Writes to status or unmapped offsets change nothing.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_reg   <= RST_ZERO;
            power_reg    <= RST_POWER;
            config_reg   <= RST_CONFIG;
            port_cfg_reg <= RST_ZERO;
        end else if (psel && penable && pwrite) begin
            if (paddr == OFS_ENABLE) begin
                enable_reg <= pwdata[7:0];
            end
            if (paddr == OFS_POWER) begin
                power_reg <= pwdata[7:0];
            end
            if (paddr == OFS_CONFIG) begin
                config_reg <= pwdata[7:0];
            end
            if (paddr == OFS_PORT_CFG) begin
                port_cfg_reg <= pwdata[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Event detection; inputs are synchronous to pclk.
    // The detector history resets high, its healthy level, so release
    // from reset is never taken for a supply drop.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pins_prev_reg <= 6'h00;
            lvd_prev_reg  <= 1'b1;
        end else begin
            pins_prev_reg <= events.port_pins;
            lvd_prev_reg  <= events.lvd_out;
        end
    end

    // Per-pin change detection, qualified by direction and wake bit.
    // Pin zero loses change detection while it is the external input.
    for (genvar i = 0; i < 6; i++) begin : g_pin
        if (i == 0) begin : g_zero
            assign change_vec[i] = (events.port_pins[i] ^ pins_prev_reg[i]) &
                                   events.port_is_input[i] & port_cfg_reg[i] &
                                   !port_cfg_reg[BIT_EXT_SELECT];
        end else begin : g_other
            assign change_vec[i] = (events.port_pins[i] ^ pins_prev_reg[i]) &
                                   events.port_is_input[i] & port_cfg_reg[i];
        end
    end

    // Edge select high picks rising, low picks falling.
    assign ext_edge = port_cfg_reg[BIT_EXT_SELECT] &&
                      (port_cfg_reg[BIT_EDGE_SELECT] ?
                       (events.port_pins[0] && !pins_prev_reg[0]) :
                       (!events.port_pins[0] && pins_prev_reg[0]));

    // Collect hardware set requests.
    // Bits 5 and 7 have no source and always read as zero.
    always_comb begin
        set_vec                   = 8'h00;
        set_vec[BIT_FIRST_TIMER]  = events.timer_overflow;
        set_vec[BIT_SECOND_TIMER] = events.timer_underflow;
        set_vec[BIT_PORT_CHANGE]  = |change_vec;
        set_vec[BIT_EXTERNAL]     = ext_edge;
        set_vec[BIT_LOW_VOLTAGE]  = lvd_prev_reg && !events.lvd_out;
        set_vec[BIT_WATCHDOG]     = wdt_timeout && config_reg[BIT_CFG_IRQ_MODE];
    end

    // Firmware writes of zero clear; a set in the same cycle wins.
    // Writing ones keeps a flag, so one source clears without a race.
    assign flag_next = (flag_wr ? (flag_reg & pwdata[7:0]) : flag_reg) | set_vec;

    // Sticky flag register.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_reg <= RST_ZERO;
        end else begin
            flag_reg <= flag_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt request and vectoring.
    // All sources share one vector; the handler polls the flags.
    assign irq_req  = gie_reg && |(flag_reg & enable_reg);
    assign take_irq = irq_req && core_cmd.boundary && !core_cmd.swi;

    // Global enable; automatic clears outrank instruction sets.
    // An enable in the same cycle as a take cannot let nesting in.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gie_reg <= 1'b0;
        end else if (core_cmd.swi || take_irq) begin
            gie_reg <= 1'b0;
        end else if (core_cmd.disable_irq_instr) begin
            gie_reg <= 1'b0;
        end else if (core_cmd.enable_irq_instr || core_cmd.reti) begin
            gie_reg <= 1'b1;
        end
    end

    // Redirect pulse and vector for the next fetch.
    // The vector holds between redirects.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fetch_redirect <= 1'b0;
            fetch_vector   <= 10'h000;
        end else begin
            fetch_redirect <= core_cmd.swi || take_irq;
            if (core_cmd.swi) begin
                fetch_vector <= SWI_VECTOR;
            end else if (take_irq) begin
                fetch_vector <= HW_VECTOR;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Watchdog; the tick free-runs and is never gated by sleep modes.
    // Stopping keeps the counts, and a restart may see its first tick
    // up to one tick period early, as the divider never stops.
    assign wdt_running = config_reg[BIT_CFG_WDT_ON] && power_reg[BIT_RUN];
    assign wdt_tick    = (tick_cnt_reg == 16'(TICK_CYCLES - 1));

    // Base period selection.
    // Periods are counted in base ticks of TICK_CYCLES clocks each.
    always_comb begin
        unique case (config_reg[BIT_CFG_PERIOD +: 2])
            2'h0: period_ticks = WDT_P0_TICKS;
            2'h1: period_ticks = WDT_P1_TICKS;
            2'h2: period_ticks = WDT_P2_TICKS;
            2'h3: period_ticks = WDT_P3_TICKS;
        endcase
    end

    // Assigned prescaler ratio: 1..128 in reset mode, 2..256 in interrupt mode.
    // Interrupt mode doubles each assigned ratio; unassigned, the ratio is one in both modes.
    always_comb begin
        if (!power_reg[BIT_ASSIGN]) begin
            pre_limit = 8'h00;
        end else if (config_reg[BIT_CFG_IRQ_MODE]) begin
            pre_limit = 8'((9'h002 << power_reg[2:0]) - 9'h001);
        end else begin
            pre_limit = 8'((9'h001 << power_reg[2:0]) - 9'h001);
        end
    end

    // A base period ends on its last tick; the prescaler counts periods.
    assign base_expire = wdt_running && wdt_tick && (wdt_cnt_reg == period_ticks - 9'h001);
    assign wdt_timeout = base_expire && (pre_cnt_reg == pre_limit) && !core_cmd.clear_watchdog_instr;

    // Tick divider runs continuously from reset.
    // Nothing but reset stops it, so standby and halt keep it counting.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_reg <= 16'h0000;
        end else if (wdt_tick) begin
            tick_cnt_reg <= 16'h0000;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 16'h0001;
        end
    end

    // Base counter and prescaler; clear-watchdog restarts both.
    // A clear in the timeout cycle wins, so a timely clear is never lost.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdt_cnt_reg <= 9'h000;
            pre_cnt_reg <= 8'h00;
        end else if (core_cmd.clear_watchdog_instr || wdt_timeout) begin
            wdt_cnt_reg <= 9'h000;
            pre_cnt_reg <= 8'h00;
        end else if (base_expire) begin
            wdt_cnt_reg <= 9'h000;
            pre_cnt_reg <= pre_cnt_reg + 8'h01;
        end else if (wdt_running && wdt_tick) begin
            wdt_cnt_reg <= wdt_cnt_reg + 9'h001;
        end
    end

    // Timeout status and the reset request pulse.
    // The reset request lasts one cycle; system reset logic stretches it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timeout_reg <= 1'b1;
            wdt_reset   <= 1'b0;
        end else begin
            wdt_reset <= wdt_timeout && !config_reg[BIT_CFG_IRQ_MODE];
            if (wdt_timeout) begin
                timeout_reg <= 1'b0;
            end else if (core_cmd.clear_watchdog_instr) begin
                timeout_reg <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    // Each property watches the state or output that carries its rule.
    property p_swi_vector;
        @(posedge pclk) disable iff (!presetn)
        core_cmd.swi |=> fetch_redirect && (fetch_vector == SWI_VECTOR) && !gie_reg;
    endproperty
    a_swi_vector: assert property (p_swi_vector) else $error("software vector wrong");

    property p_reti_sets;
        @(posedge pclk) disable iff (!presetn)
        (core_cmd.reti && !core_cmd.swi && !take_irq && !core_cmd.disable_irq_instr) |=> gie_reg;
    endproperty
    a_reti_sets: assert property (p_reti_sets) else $error("return left enable low");

    property p_disable_irq_instr_clears;
        @(posedge pclk) disable iff (!presetn)
        core_cmd.disable_irq_instr |=> !gie_reg;
    endproperty
    a_disable_irq_instr_clears: assert property (p_disable_irq_instr_clears) else $error("disable did not clear");

    property p_hw_take;
        @(posedge pclk) disable iff (!presetn)
        (irq_req && core_cmd.boundary && !core_cmd.swi) |=>
            fetch_redirect && (fetch_vector == HW_VECTOR) && !gie_reg ##1
            (!fetch_redirect || $past(core_cmd.swi));
    endproperty
    a_hw_take: assert property (p_hw_take) else $error("hardware vector wrong");

    property p_request;
        @(posedge pclk) disable iff (!presetn)
        (gie_reg && !psel && !core_cmd.swi && !core_cmd.disable_irq_instr && !take_irq &&
         ((set_vec & enable_reg) != 8'h00)) |=> irq_req;
    endproperty
    a_request: assert property (p_request) else $error("request mismatch");

    property p_sticky;
        @(posedge pclk) disable iff (!presetn)
        !flag_wr |=> ((flag_reg & $past(flag_reg)) == $past(flag_reg));
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag lost without write");

    property p_set_wins;
        @(posedge pclk) disable iff (!presetn)
        (set_vec != 8'h00) |=> ((flag_reg & $past(set_vec)) == $past(set_vec));
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("event lost to clear");

    property p_read_mask;
        @(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && paddr == OFS_FLAG) |=>
            (prdata[7:0] == $past(flag_reg & enable_reg));
    endproperty
    a_read_mask: assert property (p_read_mask) else $error("flag read unmasked");

    property p_timeout_status;
        @(posedge pclk) disable iff (!presetn)
        wdt_timeout |=> !timeout_reg && (wdt_reset == !$past(config_reg[BIT_CFG_IRQ_MODE]));
    endproperty
    a_timeout_status: assert property (p_timeout_status) else $error("timeout effect wrong");

    property p_clear_watchdog;
        @(posedge pclk) disable iff (!presetn)
        core_cmd.clear_watchdog_instr |=> (wdt_cnt_reg == 9'h000) && (pre_cnt_reg == 8'h00) && timeout_reg;
    endproperty
    a_clear_watchdog: assert property (p_clear_watchdog) else $error("clear watchdog failed");

    property p_pin_zero_mask;
        @(posedge pclk) disable iff (!presetn)
        port_cfg_reg[BIT_EXT_SELECT] |-> !change_vec[0];
    endproperty
    a_pin_zero_mask: assert property (p_pin_zero_mask) else $error("pin zero change seen");

    property p_stopped;
        @(posedge pclk) disable iff (!presetn)
        (!wdt_running && !core_cmd.clear_watchdog_instr) |=> $stable(wdt_cnt_reg) && !$past(wdt_timeout);
    endproperty
    a_stopped: assert property (p_stopped) else $error("stopped watchdog counted");

endmodule

`default_nettype wire

// *** inc/iwu_pkg.sv ***
// Operation
// - Software interrupt vectors to 0x001, clears enable.
// - Return-from-interrupt sets global enable, resumes.
// - Enable/disable instructions drive global enable.
// - Events set sticky flags; firmware zero clears.
// - Flag reads back only where enabled.
// - Enabled pending flag vectors to 0x008.
// - First timer overflow sets its flag.
// - Second timer underflow sets its flag.
// - Watchdog timeout in interrupt mode sets flag.
// - Input pin change with wake bit flags.
// - External select masks pin zero change.
// - Selected pin zero edge sets external flag.
// - Falling low-voltage output sets its flag.
// - Run bit starts and stops watchdog.
// - Timeout resets or interrupts, clears status.
// - Base timeout selectable: 3.5/15/60/250 ms.
// - Assigned prescaler extends watchdog period.
// - Clear-watchdog clears counts, sets status.
// - Watchdog counts regardless of sleep modes.
// - Watchdog flag and enable at bit 6.
// - Second timer bit 3, first timer bit 0.
`default_nettype none

package iwu_pkg;

    // Clock rate of the bus and instruction side.
    localparam int unsigned CLK_HZ          = 100_000_000;

    // Register byte offsets.
    localparam logic [11:0] OFS_FLAG        = 12'h000;
    localparam logic [11:0] OFS_ENABLE      = 12'h004;
    localparam logic [11:0] OFS_POWER       = 12'h008;
    localparam logic [11:0] OFS_CONFIG      = 12'h00c;
    localparam logic [11:0] OFS_PORT_CFG    = 12'h010;
    localparam logic [11:0] OFS_STATUS      = 12'h014;

    // Flag and enable bit positions.
    localparam int unsigned BIT_FIRST_TIMER = 0;
    localparam int unsigned BIT_PORT_CHANGE = 1;
    localparam int unsigned BIT_EXTERNAL    = 2;
    localparam int unsigned BIT_SECOND_TIMER = 3;
    localparam int unsigned BIT_LOW_VOLTAGE = 4;
    localparam int unsigned BIT_WATCHDOG    = 6;

    // Power control fields.
    localparam int unsigned BIT_RUN         = 7;
    localparam int unsigned BIT_ASSIGN      = 3;

    // Configuration fields.
    localparam int unsigned BIT_CFG_WDT_ON  = 0;
    localparam int unsigned BIT_CFG_IRQ_MODE = 1;
    localparam int unsigned BIT_CFG_PERIOD  = 2;

    // Port configuration fields.
    localparam int unsigned BIT_EXT_SELECT  = 6;
    localparam int unsigned BIT_EDGE_SELECT = 7;

    // Status fields.
    localparam int unsigned BIT_TIMEOUT     = 0;
    localparam int unsigned BIT_GIE         = 1;

    // Reset values.
    localparam logic [7:0] RST_POWER        = 8'h80;
    localparam logic [7:0] RST_CONFIG       = 8'h01;
    localparam logic [7:0] RST_ZERO         = 8'h00;

    // Fetch vectors.
    localparam logic [9:0] SWI_VECTOR       = 10'h001;
    localparam logic [9:0] HW_VECTOR        = 10'h008;

    // Watchdog base tick and timeout periods in microseconds.
    localparam int unsigned WDT_TICK_US     = 500;
    localparam int unsigned WDT_TICK_CYCLES = WDT_TICK_US * (CLK_HZ / 1_000_000);
    localparam int unsigned WDT_P0_US       = 3500;
    localparam int unsigned WDT_P1_US       = 15000;
    localparam int unsigned WDT_P2_US       = 60000;
    localparam int unsigned WDT_P3_US       = 250000;
    localparam logic [8:0]  WDT_P0_TICKS    = 9'(WDT_P0_US / WDT_TICK_US);
    localparam logic [8:0]  WDT_P1_TICKS    = 9'(WDT_P1_US / WDT_TICK_US);
    localparam logic [8:0]  WDT_P2_TICKS    = 9'(WDT_P2_US / WDT_TICK_US);
    localparam logic [8:0]  WDT_P3_TICKS    = 9'(WDT_P3_US / WDT_TICK_US);

    // Instruction strobes from the core, each a one-cycle pulse.
    typedef struct packed {
        logic swi;
        logic reti;
        logic enable_irq_instr;
        logic disable_irq_instr;
        logic clear_watchdog_instr;
        logic boundary;
    } iwu_core_cmd_s;

    // Event sources from the peripherals.
    typedef struct packed {
        logic       timer_overflow;
        logic       timer_underflow;
        logic [5:0] port_pins;
        logic [5:0] port_is_input;
        logic       lvd_out;
    } iwu_event_in_s;

endpackage

`default_nettype wire

// *** verif/iwu_core_model.sv ***
`default_nettype none

////////////////////////////////////////////////////////////////////////
// Stands in for the core sequencer and the peripheral event sources.
module iwu_core_model (
    // Clock.
    input  wire logic                    pclk,
    // Strobes and event levels toward the unit.
    output var iwu_pkg::iwu_core_cmd_s   core_cmd,
    output var iwu_pkg::iwu_event_in_s   events
);
    timeunit 1ns;
    timeprecision 1ps;
    import iwu_pkg::*;

    logic last_eni;  // The last strobe sent was an enable.

    // Quiet core, healthy supply, all pins low and configured as outputs.
    initial begin
        core_cmd = '0;
        events   = 15'h0001;
        last_eni = 1'b0;
    end

    // Sends one instruction strobe for exactly one cycle.
    task automatic cmd(input iwu_core_cmd_s c);
        if (c.reti && last_eni) begin
            @(posedge pclk);
        end
        @(posedge pclk);
        core_cmd <= c;
        @(posedge pclk);
        core_cmd <= '0;
        last_eni = c.enable_irq_instr;
    endtask

    // Applies a new set of event levels at the next edge.
    task automatic ev(input iwu_event_in_s e);
        @(posedge pclk);
        events <= e;
    endtask
endmodule

`default_nettype wire

// *** verif/tb.sv ***
`default_nettype none

////////////////////////////////////////////////////////////////////////
// Self-checking bench: APB register access plus core and event stimulus.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import iwu_pkg::*;

    localparam int TK  = 4;     // Short watchdog tick, in cycles.
    localparam int LIM = 3000;  // Longest watch for a timeout.
    // Strobes in the order swi, reti, eni, disable_irq_instr, clear_watchdog_instr, boundary.
    localparam iwu_core_cmd_s SWI = 6'h20, RETI = 6'h10, ENABLE_IRQ_INSTR = 6'h08;
    localparam iwu_core_cmd_s DISABLE_IRQ_INSTR = 6'h04, CLR = 6'h02, BND = 6'h01;

    logic          pclk = 1'b0;
    logic          presetn = 1'b0;
    logic          psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0]   paddr = 12'h000;
    logic [31:0]   pwdata = 32'h0, prdata, rv;
    logic          pready, pslverr, re, irq_req, fetch_redirect, wdt_reset;
    logic [9:0]    fetch_vector;
    iwu_core_cmd_s core_cmd;
    iwu_event_in_s events, ev_v;
    int            errors = 0, tests_run = 0, n, e;
    // Watchdog cases: configuration, power control, base period table.
    logic [7:0] cfg_t [8] = '{8'h01, 8'h05, 8'h09, 8'h0d, 8'h01, 8'h03, 8'h03, 8'h01};
    logic [7:0] pwr_t [8] = '{8'h80, 8'h80, 8'h80, 8'h80, 8'h8a, 8'h80, 8'h89, 8'h00};
    logic [8:0] per_t [4] = '{WDT_P0_TICKS, WDT_P1_TICKS, WDT_P2_TICKS, WDT_P3_TICKS};

    // Free-running 100 MHz clock.
    always #5 pclk = ~pclk;

    iwu_unit #(.TICK_CYCLES(TK)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .core_cmd(core_cmd), .events(events),
        .irq_req(irq_req), .fetch_redirect(fetch_redirect),
        .fetch_vector(fetch_vector), .wdt_reset(wdt_reset)
    );
    iwu_core_model core_u (.pclk(pclk), .core_cmd(core_cmd), .events(events));

    ////////////////////////////////////////////////////////////////////
    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Counts a comparison and reports a mismatch at once.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One APB transfer; the request holds until pready is seen high.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rv = prdata;
        re = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            errors++;
            stop_test();
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    // Reads a register and compares the masked value.
    task automatic rdc(input logic [11:0] a, input logic [31:0] x, input logic [31:0] m = '1);
        apb(1'b0, a, 32'h0);
        chk(rv & m, x);
    endtask

    // Toggles one event line; two calls make a one-cycle pulse.
    task automatic flip(input int b);
        ev_v[b] = ~ev_v[b];
        core_u.ev(ev_v);
    endtask

    ////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        ev_v = 15'h0001;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values, a refused status write, an unmapped address.
        rdc(OFS_STATUS, 32'h01);
        wr(OFS_STATUS, 32'h00);
        rdc(OFS_STATUS, 32'h01);
        rdc(OFS_POWER, 32'h80);
        wr(OFS_POWER, 32'h00);
        rdc(OFS_CONFIG, 32'h01);
        rdc(OFS_FLAG, 32'h00);
        rdc(OFS_ENABLE, 32'h00);
        rdc(OFS_PORT_CFG, 32'h00);
        apb(1'b0, 12'h018, 32'h0);
        chk({rv[30:0], re}, 32'h1);
        $display("register test done");
        // Global enable by instruction, software interrupt.
        core_u.cmd(ENABLE_IRQ_INSTR);
        rdc(OFS_STATUS, 32'h02, 32'h02);
        core_u.cmd(DISABLE_IRQ_INSTR);
        rdc(OFS_STATUS, 32'h00, 32'h02);
        core_u.cmd(RETI);
        rdc(OFS_STATUS, 32'h02, 32'h02);
        for (int k = 0; k < 2; k++) begin
            core_u.cmd(SWI);
            #1;
            chk({21'h0, fetch_redirect, fetch_vector}, {21'h0, 1'b1, SWI_VECTOR});
            rdc(OFS_STATUS, 32'h00, 32'h02);
        end
        $display("instruction test done");
        // Sticky flags, read masking, firmware clear.
        flip(14);
        flip(14);
        rdc(OFS_FLAG, 32'h00);
        wr(OFS_ENABLE, 32'h5f);
        rdc(OFS_FLAG, 32'h01);
        flip(13);
        flip(13);
        rdc(OFS_FLAG, 32'h09);
        flip(0);
        flip(0);
        rdc(OFS_FLAG, 32'h19);
        wr(OFS_FLAG, 32'hf6);
        rdc(OFS_FLAG, 32'h10);
        wr(OFS_FLAG, 32'h00);
        // Pin change on an input, then pin zero edges with external select.
        ev_v.port_is_input = 6'h3f;
        core_u.ev(ev_v);
        wr(OFS_PORT_CFG, 32'h3f);
        flip(10);
        rdc(OFS_FLAG, 32'h02);
        wr(OFS_FLAG, 32'h00);
        for (int k = 0; k < 2; k++) begin
            wr(OFS_PORT_CFG, k ? 32'h41 : 32'hc1);
            flip(7);
            rdc(OFS_FLAG, k ? 32'h00 : 32'h04);
            flip(7);
            rdc(OFS_FLAG, 32'h04);
            wr(OFS_FLAG, 32'h00);
        end
        $display("event test done");
        // Hardware interrupt gated by the global enable, then taken.
        wr(OFS_ENABLE, 32'h01);
        flip(14);
        flip(14);
        core_u.cmd(BND);
        #1;
        chk({31'h0, fetch_redirect}, 32'h0);
        core_u.cmd(ENABLE_IRQ_INSTR);
        #1;
        chk({31'h0, irq_req}, 32'h1);
        core_u.cmd(BND);
        #1;
        chk({20'h0, fetch_redirect, fetch_vector, irq_req}, {20'h0, 1'b1, HW_VECTOR, 1'b0});
        rdc(OFS_FLAG, 32'h01);
        wr(OFS_FLAG, 32'h00);
        $display("interrupt test done");
        // Watchdog periods, prescaler, modes and run bit.
        wr(OFS_ENABLE, 32'h40);
        core_u.cmd(ENABLE_IRQ_INSTR);
        for (int i = 0; i < 8; i++) begin
            wr(OFS_POWER, 32'h00);
            core_u.cmd(CLR);
            wr(OFS_CONFIG, {24'h0, cfg_t[i]});
            wr(OFS_POWER, {24'h0, pwr_t[i]});
            e = !pwr_t[i][7] ? LIM : int'(per_t[cfg_t[i][3:2]]) * TK *
                (pwr_t[i][3] ? (1 << (int'(pwr_t[i][2:0]) + int'(cfg_t[i][1]))) : 1);
            n = 0;
            do begin
                @(posedge pclk);
                #1;
                n++;
            end while ((cfg_t[i][1] ? irq_req : wdt_reset) !== 1'b1 && n < LIM);
            chk({31'h0, n + TK + 2 >= e && n <= e + TK + 2}, 32'h1);
            rdc(OFS_STATUS, {31'h0, e == LIM}, 32'h01);
            rdc(OFS_FLAG, {25'h0, cfg_t[i][1] && e != LIM, 6'h0});
            wr(OFS_FLAG, 32'h00);
        end
        $display("watchdog test done");
        stop_test();
    end
endmodule

`default_nettype wire
